// ===== config_word_reset_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module config_word_reset_control_tb;
    import cwr_pkg::*;
    localparam int LD = 4;
    localparam int PT = 3;
    localparam logic [31:0] PWR = 32'h0000_000C;
    logic sys_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, cfg_load, ext_reset_n_in;
    logic ext_reset_n_out, ext_reset_n_oe, ext_pullup_en, brownout_in, wdt_timeout, sleep_state;
    logic flash_wr_req, flash_wr_blocked, chip_reset, wake_pulse, watchdog_enable, brownout_level_select;
    logic data_protect_on, program_protect_on, erase_data_req, erase_prog_req, clock_output_en, osc1_io, osc2_io;
    logic osc_stop;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [15:0] cfg_one_in, cfg_two_in, c;
    logic [12:0] flash_wr_addr, a;
    logic [2:0] hsize;
    logic [1:0] htrans;
    cwr_kind_t reset_kind;
    cwr_osc_t osc_select;
    int n_errors = 0, total_checks = 0, n, k, m;
    assign hready = hreadyout;
    cwr_top #(.LF_DIV_P(LD), .POWERUP_DELAY_TIMER_TICKS_P(PT), .GLITCH_CYC_P(3)) dut_u (.*);
    cwr_pin_model pin_u (.sys_clk(sys_clk), .pullup_en(ext_pullup_en), .dev_oe(ext_reset_n_oe),
        .dev_out(ext_reset_n_out), .pin_level(ext_reset_n_in));
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task conclude();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    function automatic logic [2:0] dec(input logic [2:0] o);
        case (o)
            3'h7: dec = 3'h4;
            3'h6, 3'h3: dec = 3'h1;
            3'h5: dec = 3'h6;
            3'h4: dec = 3'h3;
            default: dec = 3'h0;
        endcase
    endfunction : dec
    function automatic logic [12:0] lim(input logic [1:0] w);
        case (w)
            2'h0: lim = 13'h07FF;
            2'h1: lim = 13'h03FF;
            2'h2: lim = 13'h00FF;
            default: lim = 13'h0000;
        endcase
    endfunction : lim
    function automatic logic [31:0] st(input logic t, input logic p, input cwr_kind_t kd);
        st = {27'h0, kd, t, p};
    endfunction : st
    task wt();
        int i;
        i = 0;
        do begin
            @(posedge sys_clk);
            i++;
        end while (hready !== 1'b1 && i < 50);
        if (hready !== 1'b1) begin
            $display("Error hready expected 1 seen %b", hready);
            n_errors++;
            conclude();
        end
    endtask : wt
    task xfer(input logic w, input logic [31:0] ad, input logic [31:0] d);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= ad;
        hwrite <= w;
        wt();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wt();
        r = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : xfer
    task stat(input logic t, input logic p, input cwr_kind_t kd);
        xfer(1'b0, {24'h0, ADDR_STATUS}, 32'h0);
        chk("status", st(t, p, kd), r);
        chk("kind", {29'h0, kd}, {29'h0, reset_kind});
    endtask : stat
    task load(input logic [15:0] o, input logic [15:0] t);
        @(posedge sys_clk);
        cfg_one_in <= o;
        cfg_two_in <= t;
        cfg_load <= 1'b1;
        @(posedge sys_clk);
        cfg_load <= 1'b0;
        n = 0;
        k = 0;
        repeat (3) begin
            @(negedge sys_clk);
            n += (erase_data_req !== 1'b0);
            k += (erase_prog_req !== 1'b0);
        end
    endtask : load
    task wfor(input logic v);
        m = 0;
        while (chip_reset !== v && m < 200) begin
            @(negedge sys_clk);
            m++;
        end
        if (chip_reset !== v) begin
            $display("Error chip_reset expected %b seen %b", v, chip_reset);
            n_errors++;
            conclude();
        end
    endtask : wfor
    task fw(input logic [12:0] ad);
        @(posedge sys_clk);
        flash_wr_req <= 1'b1;
        flash_wr_addr <= ad;
        @(posedge sys_clk);
        flash_wr_req <= 1'b0;
        @(negedge sys_clk);
    endtask : fw
    task wdt(input logic s);
        @(posedge sys_clk);
        sleep_state <= s;
        wdt_timeout <= 1'b1;
        @(posedge sys_clk);
        wdt_timeout <= 1'b0;
        @(negedge sys_clk);
    endtask : wdt
    task bor();
        @(posedge sys_clk);
        brownout_in <= 1'b1;
        repeat (5) @(posedge sys_clk);
        brownout_in <= 1'b0;
        @(negedge sys_clk);
        wfor(1'b0);
    endtask : bor
    task press_watch(input int cyc);
        @(posedge sys_clk);
        fork
            pin_u.press(cyc);
        join_none
        @(negedge sys_clk);
    endtask : press_watch
    initial begin
        {hsel, hwrite, cfg_load, brownout_in, wdt_timeout, sleep_state, flash_wr_req} = '0;
        {haddr, hwdata, htrans, flash_wr_addr} = '0;
        hsize = 3'h2;
        cfg_one_in = 16'hFFFF;
        cfg_two_in = 16'hFFFF;
        rst_n = 1'b0;
        k = $urandom(66);
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        stat(1'b1, 1'b1, KIND_POR);
        xfer(1'b0, PWR, 32'h0);
        chk("por_flag", 32'h0, r);
        load(16'hFF2F, 16'hFFFF);
        chk("held", 1, chip_reset);
        chk("pullup", 1, ext_pullup_en);
        chk("prog_prot", 1, {31'h0, program_protect_on});
        wfor(1'b0);
        chk("timer", 1, m + 3 >= LD * PT);
        $display("test startup done");
        for (int i = 0; i < 8; i++) begin
            c = {8'hFF, 2'h3, 1'h1, 1'($urandom), 1'h1, 3'(i)};
            load(c, {5'h1F, 2'(i), 1'(i >> 2), 8'hFF});
            wfor(1'b0);
            chk("osc", {29'h0, 3'(i)}, {29'h0, osc_select});
            chk("pins", {29'h0, dec(3'(i))}, {29'h0, clock_output_en, osc1_io, osc2_io});
            chk("bor_lvl", i >> 2, {31'h0, brownout_level_select});
            chk("wdt_en", 1, {31'h0, watchdog_enable});
            xfer(1'b0, 32'h0, 32'h0);
            chk("cfg_one", {16'h0, c}, r);
            for (int j = 0; j < 3; j++) begin
                a = (j == 2) ? 13'($urandom) : lim(2'(i)) + 13'(j);
                fw(a);
                chk("wr_block", {31'h0, i % 4 != 3 && a <= lim(2'(i))}, {31'h0, flash_wr_blocked});
            end
        end
        $display("test decode done");
        load(16'hFF2F, 16'hFFFF);
        load(16'hFFEF, 16'hFFFF);
        chk("erase_data", 1, n);
        chk("erase_prog", 1, k);
        load(16'hFFEF, 16'hFFFF);
        chk("erase_none", 0, n + k);
        wfor(1'b0);
        xfer(1'b1, 32'h0, 32'h0);
        xfer(1'b0, 32'h0, 32'h0);
        chk("cfg_ro", 32'h0000_FFEF, r);
        xfer(1'b0, {24'h0, ADDR_CFG_TWO}, 32'h0);
        chk("cfg_two", 32'h0000_FFFF, r);
        xfer(1'b1, 32'h0000_0040, 32'hFFFF_FFFF);
        xfer(1'b0, 32'h0000_0040, 32'h0);
        chk("unmapped", 32'h0, r);
        xfer(1'b1, PWR, 32'h0000_0002);
        xfer(1'b0, PWR, 32'h0);
        chk("por_flag", 32'h0000_0002, r);
        $display("test registers done");
        wdt(1'b1);
        chk("wake", 1, {31'h0, wake_pulse & ~chip_reset});
        stat(1'b0, 1'b0, KIND_WDT_SLEEP);
        wdt(1'b0);
        wfor(1'b1);
        wfor(1'b0);
        stat(1'b0, 1'b0, KIND_WDT_RUN);
        xfer(1'b0, PWR, 32'h0);
        chk("por_kept", 32'h0000_0002, r);
        $display("test watchdog done");
        press_watch(2);
        k = 0;
        repeat (15) begin
            @(negedge sys_clk);
            k += (chip_reset !== 1'b0);
        end
        chk("glitch", 0, k);
        press_watch(20);
        wfor(1'b1);
        @(negedge sys_clk);
        chk("osc_stop", 1, {31'h0, osc_stop});
        chk("pin_oe", 0, {31'h0, ext_reset_n_oe});
        wfor(1'b0);
        stat(1'b0, 1'b0, KIND_EXT_RUN);
        @(posedge sys_clk);
        sleep_state <= 1'b1;
        press_watch(20);
        wfor(1'b1);
        wfor(1'b0);
        @(posedge sys_clk);
        sleep_state <= 1'b0;
        stat(1'b1, 1'b0, KIND_EXT_SLEEP);
        $display("test pin done");
        bor();
        chk("bor_hold", 1, m >= LD * PT);
        stat(1'b1, 1'b1, KIND_BOR);
        load(16'hFFFF, 16'hFFFF);
        wfor(1'b0);
        bor();
        chk("bor_fast", 1, m < LD * PT);
        load(16'hFFDF, 16'hFFFF);
        chk("pullup", 0, {31'h0, ext_pullup_en});
        press_watch(20);
        k = 0;
        repeat (30) begin
            @(negedge sys_clk);
            k += (chip_reset !== 1'b0);
        end
        chk("pin_off", 0, k);
        load(16'hFFD7, 16'hFFFF);
        chk("wdt_off", 0, {31'h0, watchdog_enable});
        xfer(1'b1, {24'h0, ADDR_WDT_CTRL}, 32'h1);
        repeat (2) @(negedge sys_clk);
        chk("wdt_soft", 1, {31'h0, watchdog_enable});
        $display("test brownout done");
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        stat(1'b1, 1'b1, KIND_POR);
        xfer(1'b0, PWR, 32'h0);
        chk("por_reset", 32'h0, r);
        $display("test reset done");
        conclude();
    end
endmodule : config_word_reset_control_tb
`default_nettype wire

// ===== cwr_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module cwr_pin_model (
    input wire logic sys_clk,
    input wire logic pullup_en,
    input wire logic dev_oe,
    input wire logic dev_out,
    output logic pin_level
);
    logic drive_low = 1'b0;
    logic last = 1'b1;
    // undriven pin without pull-up floats, modelled as a toggling level
    always @(posedge sys_clk) last <= pin_level;
    assign pin_level = dev_oe ? dev_out : drive_low ? 1'b0 : pullup_en ? 1'b1 : ~last;
    // hold the pin low for some cycles
    task press(input int cyc);
        drive_low <= 1'b1;
        repeat (cyc) @(posedge sys_clk);
        drive_low <= 1'b0;
    endtask : press
endmodule : cwr_pin_model
`default_nettype wire

// ===== cwr_pkg.sv
`default_nettype none
package cwr_pkg;
    // clock and timing
    localparam int unsigned SYS_HZ = 50_000_000;
    localparam int unsigned CLK_NS = 20;
    localparam int unsigned LF_HZ = 31_000;
    localparam int unsigned LF_DIV = SYS_HZ / LF_HZ;
    localparam int unsigned POWERUP_DELAY_TIMER_MS = 64;
    localparam int unsigned POWERUP_DELAY_TIMER_TICKS = POWERUP_DELAY_TIMER_MS * LF_HZ / 1000;
    localparam int unsigned GLITCH_NS = 2000;
    localparam int unsigned GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
    // register offsets
    localparam logic [7:0] ADDR_CFG_ONE = 8'h00;
    localparam logic [7:0] ADDR_CFG_TWO = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_PWR_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_WDT_CTRL = 8'h10;
    // config word one fields
    localparam int unsigned BIT_DATA_PROT = 7;
    localparam int unsigned BIT_PROG_PROT = 6;
    localparam int unsigned BIT_PIN_SEL = 5;
    localparam int unsigned BIT_POWERUP_DELAY_TIMER_DIS = 4;
    localparam int unsigned BIT_WDT_FORCE = 3;
    localparam int unsigned OSC_LSB = 0;
    // config word two fields
    localparam int unsigned WRT_LSB = 9;
    localparam int unsigned BIT_BOR_LVL = 8;
    // software register fields
    localparam int unsigned BIT_POR_FLAG = 1;
    localparam int unsigned BIT_SOFT_WDT = 0;
    localparam int unsigned BIT_PD_FLAG = 0;
    localparam int unsigned BIT_TO_FLAG = 1;
    localparam int unsigned KIND_LSB = 2;
    // reset values
    localparam logic [15:0] CFG_RESET = 16'hFFFF;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
    // self-write protection boundaries
    localparam logic [12:0] LIM_8K_00 = 13'h0FFF;
    localparam logic [12:0] LIM_7FF = 13'h07FF;
    localparam logic [12:0] LIM_3FF = 13'h03FF;
    localparam logic [12:0] LIM_0FF = 13'h00FF;

    typedef enum logic [2:0] {
        OSC_LP = 3'b000,
        OSC_XT = 3'b001,
        OSC_HS = 3'b010,
        OSC_EC = 3'b011,
        OSC_INT_IO = 3'b100,
        OSC_INT_CLK = 3'b101,
        OSC_RC_IO = 3'b110,
        OSC_RC_CLK = 3'b111
    } cwr_osc_t;

    typedef enum logic [2:0] {
        KIND_POR = 3'b000,
        KIND_WDT_RUN = 3'b001,
        KIND_WDT_SLEEP = 3'b010,
        KIND_EXT_RUN = 3'b011,
        KIND_EXT_SLEEP = 3'b100,
        KIND_BOR = 3'b101
    } cwr_kind_t;

    typedef enum logic [1:0] {
        ST_CFG = 2'b00,
        ST_HOLD = 2'b01,
        ST_TIMER = 2'b10,
        ST_RUN = 2'b11
    } cwr_state_t;
endpackage : cwr_pkg
`default_nettype wire

// ===== cwr_props.sv
`timescale 1ns/1ns
`default_nettype none
module cwr_props (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic cfg_load,
    input wire logic [15:0] cfg_one_in,
    input wire logic [15:0] cfg_two_in,
    input wire logic wdt_timeout,
    input wire logic sleep_state,
    input wire logic ext_reset_n_oe,
    input wire logic ext_pullup_en,
    input wire logic chip_reset,
    input wire logic wake_pulse,
    input wire logic watchdog_enable,
    input wire logic brownout_level_select,
    input wire logic data_protect_on,
    input wire logic program_protect_on,
    input wire logic erase_data_req,
    input wire cwr_pkg::cwr_osc_t osc_select,
    input wire logic osc_stop
);
    import cwr_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // decoded outputs settle two edges after a load
    sequence s_load;
        cfg_load ##2 1'b1;
    endsequence
    sequence s_wdt_live;
        wdt_timeout && watchdog_enable && !chip_reset;
    endsequence
    property p_data_prot; s_load |-> data_protect_on == !$past(cfg_one_in[7], 2); endproperty
    a_data_prot: assert property (p_data_prot) else $error("data protect decode");
    property p_prog_prot; s_load |-> program_protect_on == !$past(cfg_one_in[6], 2); endproperty
    a_prog_prot: assert property (p_prog_prot) else $error("program protect decode");
    property p_pullup; s_load |-> ext_pullup_en == $past(cfg_one_in[5], 2); endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up decode");
    property p_osc; s_load |-> osc_select == $past(cfg_one_in[2:0], 2); endproperty
    a_osc: assert property (p_osc) else $error("osc select decode");
    property p_bor_lvl; s_load |-> brownout_level_select == $past(cfg_two_in[8], 2); endproperty
    a_bor_lvl: assert property (p_bor_lvl) else $error("brown-out level decode");
    property p_wdt_force; s_load ##0 $past(cfg_one_in[3], 2) |-> watchdog_enable; endproperty
    a_wdt_force: assert property (p_wdt_force) else $error("watchdog not forced");
    property p_erase; erase_data_req |-> ($past(cfg_load) || $past(cfg_load, 2)) ##1 !erase_data_req; endproperty
    a_erase: assert property (p_erase) else $error("stray erase pulse");
    property p_no_drive; ext_reset_n_oe == 1'b0; endproperty
    a_no_drive: assert property (p_no_drive) else $error("reset pin driven");
    property p_osc_stop; osc_stop |-> osc_select[2] && ext_pullup_en; endproperty
    a_osc_stop: assert property (p_osc_stop) else $error("osc stop in wrong mode");
    property p_wake; s_wdt_live ##0 sleep_state |=> wake_pulse && !chip_reset; endproperty
    a_wake: assert property (p_wake) else $error("watchdog wake wrong");
    property p_wdt_run; s_wdt_live ##0 !sleep_state |=> chip_reset; endproperty
    a_wdt_run: assert property (p_wdt_run) else $error("watchdog reset missing");
endmodule : cwr_props
bind cwr_top cwr_props props_u (.*);
`default_nettype wire

// ===== cwr_top.sv
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module cwr_top #(
    parameter bit LARGE_MEM = 1'b0,
    parameter int unsigned LF_DIV_P = cwr_pkg::LF_DIV,
    parameter int unsigned POWERUP_DELAY_TIMER_TICKS_P = cwr_pkg::POWERUP_DELAY_TIMER_TICKS,
    parameter int unsigned GLITCH_CYC_P = cwr_pkg::GLITCH_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic cfg_load,
    input wire logic [15:0] cfg_one_in,
    input wire logic [15:0] cfg_two_in,
    input wire logic ext_reset_n_in,
    output logic ext_reset_n_out,
    output logic ext_reset_n_oe,
    output logic ext_pullup_en,
    input wire logic brownout_in,
    input wire logic wdt_timeout,
    input wire logic sleep_state,
    input wire logic flash_wr_req,
    input wire logic [12:0] flash_wr_addr,
    output logic flash_wr_blocked,
    output logic chip_reset,
    output logic wake_pulse,
    output cwr_pkg::cwr_kind_t reset_kind,
    output logic watchdog_enable,
    output logic brownout_level_select,
    output logic data_protect_on,
    output logic program_protect_on,
    output logic erase_data_req,
    output logic erase_prog_req,
    output cwr_pkg::cwr_osc_t osc_select,
    output logic clock_output_en,
    output logic osc1_io,
    output logic osc2_io,
    output logic osc_stop
);
    import cwr_pkg::*;

    logic [15:0] cfg_one_reg;
    logic [15:0] cfg_two_reg;
    logic [2:0] pin_sync_reg;
    logic [2:0] bor_sync_reg;
    logic bor_level_reg;
    logic [15:0] glitch_cnt_reg;
    logic ext_low_reg;
    logic [15:0] lf_cnt_reg;
    logic lf_tick;
    logic [15:0] powerup_delay_timer_cnt_reg;
    logic powerup_delay_timer_pend_reg;
    cwr_state_t state_reg;
    cwr_kind_t kind_reg;
    logic to_flag_reg;
    logic pd_flag_reg;
    logic por_flag_reg;
    logic soft_wdt_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic ext_req;
    logic bor_req;
    logic wdt_req;
    logic any_req;
    logic powerup_delay_timer_enabled;
    logic addr_ok;
    cwr_osc_t osc_code;

    function automatic logic [12:0] wr_limit(input logic [1:0] code);
        logic [12:0] lim;
        lim = LIM_0FF;
        case (code)
            2'b00: lim = LARGE_MEM ? LIM_8K_00 : LIM_7FF;
            2'b01: lim = LARGE_MEM ? LIM_7FF : LIM_3FF;
            default: lim = LIM_0FF;
        endcase
        return lim;
    endfunction : wr_limit

    // configuration words, loaded from configuration memory
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cfg_one_reg <= CFG_RESET;
            cfg_two_reg <= CFG_RESET;
        end else if (cfg_load) begin
            cfg_one_reg <= cfg_one_in;
            cfg_two_reg <= cfg_two_in;
        end
    end

    // erase requests on protection released
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            erase_data_req <= 1'b0;
            erase_prog_req <= 1'b0;
        end else begin
            erase_data_req <= cfg_load && !cfg_one_reg[BIT_DATA_PROT]
                && cfg_one_in[BIT_DATA_PROT];
            erase_prog_req <= cfg_load && !cfg_one_reg[BIT_PROG_PROT]
                && cfg_one_in[BIT_PROG_PROT];
        end
    end

    assign osc_code = cwr_osc_t'(cfg_one_reg[OSC_LSB +: 3]);
    assign powerup_delay_timer_enabled = !cfg_one_reg[BIT_POWERUP_DELAY_TIMER_DIS];

    // decoded configuration outputs
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            data_protect_on <= 1'b0;
            program_protect_on <= 1'b0;
            watchdog_enable <= 1'b0;
            brownout_level_select <= 1'b0;
            ext_pullup_en <= 1'b0;
            osc_select <= OSC_RC_CLK;
        end else begin
            data_protect_on <= !cfg_one_reg[BIT_DATA_PROT];
            program_protect_on <= !cfg_one_reg[BIT_PROG_PROT];
            watchdog_enable <= cfg_one_reg[BIT_WDT_FORCE] || soft_wdt_reg;
            brownout_level_select <= cfg_two_reg[BIT_BOR_LVL];
            ext_pullup_en <= cfg_one_reg[BIT_PIN_SEL];
            osc_select <= osc_code;
        end
    end

    // oscillator pin roles
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            clock_output_en <= 1'b0;
            osc1_io <= 1'b0;
            osc2_io <= 1'b0;
            osc_stop <= 1'b0;
        end else begin
            clock_output_en <= 1'b0;
            osc1_io <= 1'b0;
            osc2_io <= 1'b0;
            case (osc_code)
                OSC_RC_CLK: clock_output_en <= 1'b1;
                OSC_RC_IO: osc2_io <= 1'b1;
                OSC_INT_CLK: begin
                    clock_output_en <= 1'b1;
                    osc1_io <= 1'b1;
                end
                OSC_INT_IO: begin
                    osc1_io <= 1'b1;
                    osc2_io <= 1'b1;
                end
                OSC_EC: osc2_io <= 1'b1;
                default: osc2_io <= 1'b0;
            endcase
            osc_stop <= ext_req && osc_code[2];
        end
    end

    // flash self-write protection check
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            flash_wr_blocked <= 1'b0;
        end else if (flash_wr_req) begin
            flash_wr_blocked <= (cfg_two_reg[WRT_LSB +: 2] != 2'b11)
                && (flash_wr_addr <= wr_limit(cfg_two_reg[WRT_LSB +: 2]));
        end
    end

    // pin and brown-out synchronisers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_sync_reg <= 3'b111;
            bor_sync_reg <= 3'b000;
        end else begin
            pin_sync_reg <= {pin_sync_reg[1:0], ext_reset_n_in};
            bor_sync_reg <= {bor_sync_reg[1:0], brownout_in};
        end
    end

    // brown-out level taken once the last two stages agree
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bor_level_reg <= 1'b0;
        end else if (bor_sync_reg[1] == bor_sync_reg[2]) begin
            bor_level_reg <= bor_sync_reg[2];
        end
    end

    // reset pin noise filter
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            glitch_cnt_reg <= 16'h0000;
            ext_low_reg <= 1'b0;
        end else if (pin_sync_reg[1] == pin_sync_reg[2]) begin
            if (pin_sync_reg[2]) begin
                glitch_cnt_reg <= 16'h0000;
                ext_low_reg <= 1'b0;
            end else if (glitch_cnt_reg >= 16'(GLITCH_CYC_P - 1)) begin
                ext_low_reg <= 1'b1;
            end else begin
                glitch_cnt_reg <= glitch_cnt_reg + 16'h0001;
            end
        end
    end

    assign ext_req = ext_low_reg && cfg_one_reg[BIT_PIN_SEL];
    assign bor_req = bor_level_reg;
    assign wdt_req = wdt_timeout && !sleep_state;
    assign any_req = ext_req || bor_req || wdt_req;
    // the pin is never driven, not even by a watchdog reset
    assign ext_reset_n_out = 1'b0;
    assign ext_reset_n_oe = 1'b0;

    // low-frequency tick divider
    always_ff @(posedge sys_clk) begin
        if (!rst_n || lf_tick) begin
            lf_cnt_reg <= 16'h0000;
        end else begin
            lf_cnt_reg <= lf_cnt_reg + 16'h0001;
        end
    end
    assign lf_tick = lf_cnt_reg >= 16'(LF_DIV_P - 1);

    // reset sequencer
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg <= ST_CFG;
        end else begin
            case (state_reg)
                ST_CFG: if (cfg_load) begin
                    state_reg <= ST_HOLD;
                end
                ST_HOLD: if (!any_req) begin
                    state_reg <= (powerup_delay_timer_pend_reg && powerup_delay_timer_enabled) ? ST_TIMER : ST_RUN;
                end
                ST_TIMER: if (bor_req) begin
                    state_reg <= ST_HOLD;
                end else if (lf_tick && powerup_delay_timer_cnt_reg >= 16'(POWERUP_DELAY_TIMER_TICKS_P - 1)) begin
                    state_reg <= ST_HOLD;
                end
                ST_RUN: if (any_req) begin
                    state_reg <= ST_HOLD;
                end
                default: state_reg <= ST_CFG;
            endcase
        end
    end

    // power-up timer count and pending request
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            powerup_delay_timer_cnt_reg <= 16'h0000;
            powerup_delay_timer_pend_reg <= 1'b1;
        end else begin
            if (state_reg != ST_TIMER) begin
                powerup_delay_timer_cnt_reg <= 16'h0000;
            end else if (lf_tick) begin
                powerup_delay_timer_cnt_reg <= powerup_delay_timer_cnt_reg + 16'h0001;
            end
            if (bor_req) begin
                powerup_delay_timer_pend_reg <= 1'b1;
            end else if (state_reg == ST_TIMER && lf_tick
                && powerup_delay_timer_cnt_reg >= 16'(POWERUP_DELAY_TIMER_TICKS_P - 1)) begin
                powerup_delay_timer_pend_reg <= 1'b0;
            end else if (state_reg == ST_HOLD && !any_req && !powerup_delay_timer_enabled) begin
                powerup_delay_timer_pend_reg <= 1'b0;
            end
        end
    end

    assign chip_reset = (state_reg != ST_RUN);

    // reset kind and status flags
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            kind_reg <= KIND_POR;
            to_flag_reg <= 1'b1;
            pd_flag_reg <= 1'b1;
            wake_pulse <= 1'b0;
        end else begin
            wake_pulse <= 1'b0;
            if (state_reg == ST_RUN || state_reg == ST_HOLD) begin
                if (bor_req) begin
                    kind_reg <= KIND_BOR;
                    to_flag_reg <= 1'b1;
                    pd_flag_reg <= 1'b1;
                end else if (state_reg == ST_RUN && ext_req) begin
                    kind_reg <= sleep_state ? KIND_EXT_SLEEP : KIND_EXT_RUN;
                    if (sleep_state) begin
                        to_flag_reg <= 1'b1;
                        pd_flag_reg <= 1'b0;
                    end
                end else if (state_reg == ST_RUN && wdt_timeout) begin
                    kind_reg <= sleep_state ? KIND_WDT_SLEEP : KIND_WDT_RUN;
                    to_flag_reg <= 1'b0;
                    if (sleep_state) begin
                        pd_flag_reg <= 1'b0;
                        wake_pulse <= 1'b1;
                    end
                end
            end
        end
    end

    assign reset_kind = kind_reg;

    // bus address phase capture and read data
    assign addr_ok = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata <= RD_ZERO;
        end else begin
            wr_pend_reg <= addr_ok && hwrite && (hsize == 3'b010);
            if (addr_ok) begin
                wr_addr_reg <= haddr[7:0];
            end
            if (addr_ok && !hwrite) begin
                hrdata <= RD_ZERO;
                if (haddr[31:8] != 24'h00_0000) begin
                    hrdata <= RD_ZERO;
                end else if (haddr[7:0] == ADDR_CFG_ONE) begin
                    hrdata <= {16'h0000, cfg_one_reg};
                end else if (haddr[7:0] == ADDR_CFG_TWO) begin
                    hrdata <= {16'h0000, cfg_two_reg};
                end else if (haddr[7:0] == ADDR_STATUS) begin
                    hrdata[BIT_PD_FLAG] <= pd_flag_reg;
                    hrdata[BIT_TO_FLAG] <= to_flag_reg;
                    hrdata[KIND_LSB +: 3] <= kind_reg;
                end else if (haddr[7:0] == ADDR_PWR_CTRL) begin
                    hrdata[BIT_POR_FLAG] <= por_flag_reg;
                end else if (haddr[7:0] == ADDR_WDT_CTRL) begin
                    hrdata[BIT_SOFT_WDT] <= soft_wdt_reg;
                end
            end
        end
    end

    // power-on flag: cleared by power-on reset or by a software write of zero
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            por_flag_reg <= 1'b0;
        end else if (wr_pend_reg && wr_addr_reg == ADDR_PWR_CTRL) begin
            por_flag_reg <= hwdata[BIT_POR_FLAG];
        end
    end

    // software watchdog enable, returned to reset state by chip reset
    always_ff @(posedge sys_clk) begin
        if (!rst_n || chip_reset) begin
            soft_wdt_reg <= 1'b0;
        end else if (wr_pend_reg && wr_addr_reg == ADDR_WDT_CTRL) begin
            soft_wdt_reg <= hwdata[BIT_SOFT_WDT];
        end
    end
endmodule : cwr_top
`default_nettype wire
